/* File: design/sfs_map.svh */
`ifndef SFS_MAP_SVH
`define SFS_MAP_SVH

// ----------------------------------------
// control_flags field positions
// ----------------------------------------
`define SFS_C_FLUSH 7
`define SFS_C_BYPASS 6
`define SFS_C_ECHO 5
`define SFS_C_JUMP 4
`define SFS_C_OTDPOL 3
`define SFS_C_ROTEN 2
`define SFS_C_HSHOCK 1
`define SFS_C_PFOUND 0

// ----------------------------------------
// state_flags field positions
// ----------------------------------------
`define SFS_S_LENHI 7
`define SFS_S_LENLO 6
`define SFS_S_FRMERR 5
`define SFS_S_NEWFR 4
`define SFS_S_FULL 3
`define SFS_S_EMPTY 2
`define SFS_S_SHOCK 1
`define SFS_S_FILL 0

// ----------------------------------------
// reset values and timing
// ----------------------------------------
// reset sets bypass and clears every other control bit
`define SFS_CTRL_RST 8'h40
`define SFS_WORD_BITS 8
`define SFS_BIT_IDX_W 3
`define SFS_LAST_BIT 3'h7
`define SFS_CLK_NS 10
// one subcode frame, 75 per second
`define SFS_FRAME_NS 13333333
// extra slack before a frame counts as lost
`define SFS_FRAME_SLACK_DIV 8
`define SFS_SYNC_W 6
// synchroniser reset levels: load and kill idle high
`define SFS_SYNC_IDLE 6'h11

`endif

/* File: design/sfs_pkg.sv */
package sfs_pkg;

   // ----------------------------------------
   // fifo operating modes
   // ----------------------------------------
   typedef enum logic [1:0] {
      SFS_BYPASS,
      SFS_FILL,
      SFS_HOLD,
      SFS_SHOCK
   } sfs_mode_type;

endpackage

/* File: design/sfs_supervisor.sv */
// Operation
// - host shock bit forces shock mode
// - off-track enters shock unless jump busy
// - rotational shock with enable enters shock
// - lost frame, full unread, enters shock
// - position found clears shock, refills, self-clears
// - decoder hold after found re-raises shock
// - shock clears on found, flush, empty unless echo
// - shock mode persists until those events
// - full stops writing, clears fill
// - save pointer per frame, restore on found from hold or shock
// - control bit order flush down to found
// - status bit order length down to fill
// - flush resets pointers, resumes, self-clears
// - bypass routes audio, strobes high, kill
// - leaving bypass performs a flush
// - echo replays fifo until position found
// - jump busy masks off-track input
// - polarity bit selects off-track level
// - write shifts while load high, latches
// - insert missing frame pulse on output
// - status shifted out on data line
// - read with load low, rising edges
// - status read clears error, frame, full
// - reset clears control except bypass
`timescale 1ns/1ns
`default_nettype none
`include "sfs_map.svh"

module sfs_supervisor #(
   parameter int FRAME_CYCLES = `SFS_FRAME_NS / `SFS_CLK_NS,
   parameter int CNT_W = 24
) (
   // system clock and reset
   input wire logic i_ref_clk,
   input wire logic i_rst_n,
   // host serial port
   input wire logic i_host_serial_clock,
   input wire logic i_host_load_line,
   input wire logic i_host_serial_data,
   output var logic o_host_serial_data,
   output var logic o_host_serial_data_oe,
   // shock detectors and decoder markers
   input wire logic i_off_track,
   input wire logic i_decoder_hold_marker,
   input wire logic i_frame_sync_marker,
   // kill path, open drain active low
   input wire logic i_kill_n,
   input wire logic i_mute_req,
   output var logic o_mute_out,
   output var logic o_mute_out_oe,
   // fifo datapath
   input wire logic i_fifo_full,
   input wire logic i_fifo_empty,
   input wire logic [1:0] i_fifo_len,
   output var logic o_fill,
   output var logic o_bypass,
   output var logic o_flush,
   output var logic o_save_wptr,
   output var logic o_restore_wptr,
   output var logic o_echo,
   // shock and frame outputs
   output var logic o_shock_detected,
   output var logic o_rotational_shock_out,
   output var logic o_synthetic_frame_out
);

   // ----------------------------------------
   // declarations
   // ----------------------------------------
   localparam logic [CNT_W-1:0] FRAME_WIN =
      CNT_W'(FRAME_CYCLES + FRAME_CYCLES / `SFS_FRAME_SLACK_DIV);
   // stages start at the pins' idle levels, so reset gives no false kill
   localparam logic [`SFS_SYNC_W-1:0] SYNC_IDLE = `SFS_SYNC_IDLE;

   logic [`SFS_WORD_BITS-1:0] sh_q;
   logic [`SFS_BIT_IDX_W-1:0] wcnt_q;
   logic [`SFS_BIT_IDX_W-1:0] rcnt_q;
   logic wr_tgl_q;
   logic [`SFS_SYNC_W-1:0] pin_raw;
   logic [`SFS_SYNC_W-1:0] s1_q;
   logic [`SFS_SYNC_W-1:0] s2_q;
   logic [`SFS_SYNC_W-1:0] s3_q;
   logic [`SFS_SYNC_W-1:0] f_q;
   logic [`SFS_SYNC_W-1:0] fp_q;
   logic f_tgl;
   logic f_load;
   logic f_otd;
   logic f_hold;
   logic f_sync;
   logic f_kill_n;
   logic load_fall;
   logic pend_wr_q;
   logic rd_pulse;
   logic wr_pulse;
   logic [`SFS_WORD_BITS-1:0] ctrl_q;
   logic [`SFS_WORD_BITS-1:0] snap_q;
   logic [`SFS_WORD_BITS-1:0] status;
   logic [CNT_W-1:0] fcnt_q;
   logic sync_rise;
   logic lost_q;
   logic full_q;
   logic full_read_q;
   logic newfr_q;
   logic frmerr_q;
   logic byp_prev_q;
   logic pf_evt;
   logic flush_evt;
   logic otd_act;
   logic shock_set;
   logic shock_clr;
   logic shock_d;
   sfs_pkg::sfs_mode_type mode_q;
   sfs_pkg::sfs_mode_type mode_d;

   // ----------------------------------------
   // link side, on the host serial clock
   // ----------------------------------------
   // load high shifts command bits in, msb first; load low
   // shifts the captured status out. snap_q is only read
   // here while it is held steady for the whole read frame.
   always_ff @(posedge i_host_serial_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         sh_q <= '0;
         wcnt_q <= '0;
         rcnt_q <= '0;
         wr_tgl_q <= 1'b0;
         o_host_serial_data <= 1'b0;
      end else if (i_host_load_line) begin
         sh_q <= {sh_q[`SFS_WORD_BITS-2:0], i_host_serial_data};
         wcnt_q <= wcnt_q + 1'b1;
         rcnt_q <= '0;
         if (wcnt_q == `SFS_LAST_BIT) begin
            wr_tgl_q <= ~wr_tgl_q; // eighth bit in, word complete
         end
      end else begin
         o_host_serial_data <= snap_q[~rcnt_q];
         rcnt_q <= rcnt_q + 1'b1;
         wcnt_q <= '0;
      end
   end

   // ----------------------------------------
   // input synchronisers
   // ----------------------------------------
   assign pin_raw = {wr_tgl_q, i_host_load_line, i_off_track,
                     i_decoder_hold_marker, i_frame_sync_marker, i_kill_n};

   // three stages; a level is taken once stages two and three agree
   generate
      for (genvar g = 0; g < `SFS_SYNC_W; g++) begin : g_sync
         always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
            if (!i_rst_n) begin
               s1_q[g] <= SYNC_IDLE[g];
               s2_q[g] <= SYNC_IDLE[g];
               s3_q[g] <= SYNC_IDLE[g];
               f_q[g] <= SYNC_IDLE[g];
               fp_q[g] <= SYNC_IDLE[g];
            end else begin
               s1_q[g] <= pin_raw[g];
               s2_q[g] <= s1_q[g];
               s3_q[g] <= s2_q[g];
               fp_q[g] <= f_q[g];
               if (s2_q[g] == s3_q[g]) begin
                  f_q[g] <= s3_q[g];
               end
            end
         end
      end
   endgenerate

   assign f_tgl = f_q[5];
   assign f_load = f_q[4];
   assign f_otd = f_q[3];
   assign f_hold = f_q[2];
   assign f_sync = f_q[1];
   assign f_kill_n = f_q[0];

   // load falling ends a write or opens a read
   assign load_fall = fp_q[4] & ~f_load;
   assign wr_pulse = load_fall & pend_wr_q;
   assign rd_pulse = load_fall & ~pend_wr_q;

   // ----------------------------------------
   // host transfer control
   // ----------------------------------------
   // a completed eight bit word waits for load to fall
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         pend_wr_q <= 1'b0;
      end else if (f_tgl != fp_q[5]) begin
         pend_wr_q <= 1'b1;
      end else if (load_fall) begin
         pend_wr_q <= 1'b0;
      end
   end

   // status snapshot and data line enable for a read
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         snap_q <= '0;
         o_host_serial_data_oe <= 1'b0;
      end else begin
         if (rd_pulse) begin
            snap_q <= status;
         end
         o_host_serial_data_oe <= rd_pulse | (o_host_serial_data_oe & ~f_load);
      end
   end

   // status word, msb first
   always_comb begin
      status = '0;
      status[`SFS_S_LENHI] = i_fifo_len[1];
      status[`SFS_S_LENLO] = i_fifo_len[0];
      status[`SFS_S_FRMERR] = frmerr_q;
      status[`SFS_S_NEWFR] = newfr_q;
      status[`SFS_S_FULL] = full_q;
      status[`SFS_S_EMPTY] = i_fifo_empty;
      status[`SFS_S_SHOCK] = o_shock_detected;
      status[`SFS_S_FILL] = (mode_q == sfs_pkg::SFS_FILL);
   end

   // ----------------------------------------
   // control register
   // ----------------------------------------
   // found and flush act for one cycle then drop by themselves;
   // a new write in that cycle takes precedence
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         ctrl_q <= `SFS_CTRL_RST;
      end else if (wr_pulse) begin
         ctrl_q <= sh_q;
      end else begin
         ctrl_q[`SFS_C_PFOUND] <= 1'b0;
         ctrl_q[`SFS_C_FLUSH] <= 1'b0;
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         byp_prev_q <= 1'b1;
      end else begin
         byp_prev_q <= ctrl_q[`SFS_C_BYPASS];
      end
   end

   assign pf_evt = ctrl_q[`SFS_C_PFOUND];
   assign flush_evt = ctrl_q[`SFS_C_FLUSH] |
                      (byp_prev_q & ~ctrl_q[`SFS_C_BYPASS]);

   // ----------------------------------------
   // frame regeneration
   // ----------------------------------------
   assign sync_rise = f_sync & ~fp_q[1];

   // a missing sync is filled in after one frame plus slack
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         fcnt_q <= '0;
         lost_q <= 1'b0;
         o_synthetic_frame_out <= 1'b0;
      end else begin
         lost_q <= 1'b0;
         o_synthetic_frame_out <= 1'b0;
         if (sync_rise) begin
            fcnt_q <= '0;
            o_synthetic_frame_out <= 1'b1;
         end else if (fcnt_q == FRAME_WIN) begin
            fcnt_q <= '0;
            lost_q <= 1'b1;
            o_synthetic_frame_out <= 1'b1;
         end else begin
            fcnt_q <= fcnt_q + 1'b1;
         end
      end
   end

   // new frame and framing error; a read clears, an event wins
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         newfr_q <= 1'b0;
         frmerr_q <= 1'b0;
      end else begin
         if (sync_rise) begin
            newfr_q <= 1'b1;
         end else if (rd_pulse) begin
            newfr_q <= 1'b0;
         end
         if ((sync_rise & newfr_q) | lost_q) begin
            frmerr_q <= 1'b1;
         end else if (rd_pulse) begin
            frmerr_q <= 1'b0;
         end
      end
   end

   // ----------------------------------------
   // full flag tracking
   // ----------------------------------------
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         full_q <= 1'b0;
         full_read_q <= 1'b0;
      end else begin
         if (mode_q == sfs_pkg::SFS_FILL && i_fifo_full) begin
            full_q <= 1'b1;
         end else if (rd_pulse) begin
            full_q <= 1'b0;
         end
         if (rd_pulse & full_q) begin
            full_read_q <= 1'b1;
         end else if (pf_evt | flush_evt) begin
            full_read_q <= 1'b0;
         end
      end
   end

   // ----------------------------------------
   // shock processor
   // ----------------------------------------
   assign otd_act = (f_otd == ctrl_q[`SFS_C_OTDPOL]);

   // detectors are ignored in bypass, where the core is asleep
   always_comb begin
      shock_set = ~ctrl_q[`SFS_C_BYPASS] & (
         ctrl_q[`SFS_C_HSHOCK] |
         (otd_act & ~ctrl_q[`SFS_C_JUMP]) |
         (o_rotational_shock_out & ctrl_q[`SFS_C_ROTEN]) |
         (lost_q & ~full_read_q));
      shock_clr = pf_evt | flush_evt |
                  (i_fifo_empty & ~ctrl_q[`SFS_C_ECHO]);
      shock_d = o_shock_detected;
      if (shock_set) begin
         shock_d = 1'b1; // set beats a clear in the same cycle
      end else if (shock_clr) begin
         shock_d = 1'b0;
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_shock_detected <= 1'b0;
         o_rotational_shock_out <= 1'b0;
      end else begin
         o_shock_detected <= shock_d;
         // decoder still holding means it is rolling out of its fifo
         o_rotational_shock_out <= f_hold;
      end
   end

   // ----------------------------------------
   // fifo mode machine
   // ----------------------------------------
   always_comb begin
      mode_d = mode_q;
      case (mode_q)
         sfs_pkg::SFS_BYPASS: begin
            if (!ctrl_q[`SFS_C_BYPASS]) begin
               mode_d = sfs_pkg::SFS_FILL;
            end
         end
         sfs_pkg::SFS_FILL: begin
            if (shock_d) begin
               mode_d = sfs_pkg::SFS_SHOCK;
            end else if (i_fifo_full) begin
               mode_d = sfs_pkg::SFS_HOLD;
            end
         end
         sfs_pkg::SFS_HOLD: begin
            if (shock_d) begin
               mode_d = sfs_pkg::SFS_SHOCK;
            end else if (pf_evt | flush_evt) begin
               mode_d = sfs_pkg::SFS_FILL;
            end else if (i_fifo_empty & ~ctrl_q[`SFS_C_ECHO]) begin
               mode_d = sfs_pkg::SFS_FILL;
            end
         end
         sfs_pkg::SFS_SHOCK: begin
            if (!shock_d) begin
               mode_d = sfs_pkg::SFS_FILL;
            end
         end
         default: begin
            mode_d = sfs_pkg::SFS_BYPASS;
         end
      endcase
      if (ctrl_q[`SFS_C_BYPASS]) begin
         mode_d = sfs_pkg::SFS_BYPASS;
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         mode_q <= sfs_pkg::SFS_BYPASS;
      end else begin
         mode_q <= mode_d;
      end
   end

   // ----------------------------------------
   // datapath controls
   // ----------------------------------------
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_fill <= 1'b0;
         o_bypass <= 1'b1;
         o_flush <= 1'b0;
         o_save_wptr <= 1'b0;
         o_restore_wptr <= 1'b0;
         o_echo <= 1'b0;
      end else begin
         o_fill <= (mode_d == sfs_pkg::SFS_FILL);
         o_bypass <= ctrl_q[`SFS_C_BYPASS];
         o_flush <= flush_evt;
         // pointer saved at each frame end while filling
         o_save_wptr <= (mode_q == sfs_pkg::SFS_FILL) &
                        o_synthetic_frame_out;
         // flush resets pointers, so no restore then
         o_restore_wptr <= pf_evt & ~flush_evt &
                           (mode_q == sfs_pkg::SFS_HOLD ||
                            mode_q == sfs_pkg::SFS_SHOCK);
         o_echo <= ctrl_q[`SFS_C_ECHO] &
                   (mode_d == sfs_pkg::SFS_SHOCK ||
                    mode_d == sfs_pkg::SFS_HOLD);
      end
   end

   // ----------------------------------------
   // kill path
   // ----------------------------------------
   // open drain: only ever pulls low
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_mute_out <= 1'b0;
         o_mute_out_oe <= 1'b0;
      end else begin
         o_mute_out <= 1'b0;
         if (ctrl_q[`SFS_C_BYPASS]) begin
            o_mute_out_oe <= ~f_kill_n;
         end else begin
            o_mute_out_oe <= i_mute_req;
         end
      end
   end

endmodule

`default_nettype wire

/* File: tb/sfs_supervisor_checker.sv */
`timescale 1ns/1ns
`default_nettype none
module sfs_supervisor_checker (
   // clock and reset
   input wire logic i_ref_clk,
   input wire logic i_rst_n,
   // watched ports
   input wire logic i_host_load_line,
   input wire logic o_host_serial_data_oe,
   input wire logic i_kill_n,
   input wire logic o_mute_out_oe,
   input wire logic i_fifo_full,
   input wire logic i_fifo_empty,
   input wire logic i_decoder_hold_marker,
   input wire logic o_fill,
   input wire logic o_bypass,
   input wire logic o_flush,
   input wire logic o_save_wptr,
   input wire logic o_echo,
   input wire logic o_shock_detected,
   input wire logic o_rotational_shock_out,
   input wire logic o_synthetic_frame_out
);
   // ------
   // properties
   // ------
   // single domain, so one default clock and disable
   default clocking cb @(posedge i_ref_clk);
   endclocking
   default disable iff (!i_rst_n);
   AST_RESET_STATE: assert property ($rose(i_rst_n) |-> o_bypass && !o_shock_detected)
      else $error("bad state after reset");
   AST_FLUSH_PULSE: assert property (o_flush |=> !o_flush)
      else $error("flush pulse too long");
   AST_BYPASS_EXIT: assert property ($fell(o_bypass) |-> $past(o_flush) or ##[0:3] o_flush)
      else $error("no flush on bypass exit");
   AST_KILL_PASS: assert property ((o_bypass && !i_kill_n) [*6] |-> o_mute_out_oe)
      else $error("kill not passed in bypass");
   AST_FULL_STOP: assert property (i_fifo_full [*3] |-> !o_fill)
      else $error("fill kept while full");
   AST_SHOCK_NOFILL: assert property (o_shock_detected [*3] |-> !o_fill)
      else $error("fill during shock");
   AST_ROT_HOLD: assert property ((i_decoder_hold_marker && !o_bypass) [*6] |-> o_rotational_shock_out)
      else $error("hold not on rotational output");
   AST_SAVE_FILL: assert property (o_save_wptr |-> (o_fill || $past(o_fill)) ##1 !o_save_wptr)
      else $error("pointer save outside fill");
   AST_SYNTH_PULSE: assert property (o_synthetic_frame_out |=> !o_synthetic_frame_out)
      else $error("synthetic frame pulse too long");
   AST_EMPTY_CLEAR: assert property ((i_fifo_empty && !o_echo && !o_bypass) [*4] |-> !o_shock_detected)
      else $error("shock kept on empty");
   AST_OE_IDLE: assert property (i_host_load_line [*6] |-> !o_host_serial_data_oe)
      else $error("data line driven outside read");
   // main scenarios reached
   cover property (o_flush);
   cover property (o_shock_detected && o_echo);
   cover property (o_synthetic_frame_out);
endmodule
bind sfs_supervisor sfs_supervisor_checker u_chk (
   .i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_host_load_line(i_host_load_line),
   .o_host_serial_data_oe(o_host_serial_data_oe), .i_kill_n(i_kill_n),
   .o_mute_out_oe(o_mute_out_oe), .i_fifo_full(i_fifo_full), .i_fifo_empty(i_fifo_empty),
   .i_decoder_hold_marker(i_decoder_hold_marker), .o_fill(o_fill), .o_bypass(o_bypass),
   .o_flush(o_flush), .o_save_wptr(o_save_wptr), .o_echo(o_echo),
   .o_shock_detected(o_shock_detected), .o_rotational_shock_out(o_rotational_shock_out),
   .o_synthetic_frame_out(o_synthetic_frame_out)
);
`default_nettype wire

/* File: tb/sfs_host_model.sv */
`timescale 1ns/1ns
`default_nettype none
module sfs_host_model (
   // serial lines toward the device
   output var logic o_sclk,
   output var logic o_load,
   output var logic o_sda,
   input wire logic i_sda
);
   // ------
   // host transfers
   // ------
   // clock idles high and runs only inside a transfer
   initial begin
      o_sclk = 1'h1;
      o_load = 1'h1;
      o_sda = 1'h1;
   end
   // write: eight rises msb first with load high, then load low latches
   task automatic write_ctrl(input logic [7:0] v);
      for (int i = 7; i >= 0; i--) begin
         o_sclk = 1'h0;
         o_sda = v[i];
         #16;
         o_sclk = 1'h1;
         #16;
      end
      o_sda = ~v[0]; // released line must not hold the stale bit
      #60;
      o_load = 1'h0;
      #100;
      o_load = 1'h1;
      #100;
   endtask
   // read: load low, bits sampled late in each high phase
   task automatic read_stat(output logic [7:0] v);
      o_load = 1'h0;
      #100;
      for (int i = 7; i >= 0; i--) begin
         o_sclk = 1'h0;
         #16;
         o_sclk = 1'h1;
         #15;
         v[i] = i_sda;
         #1;
      end
      o_load = 1'h1;
      #100;
   endtask
endmodule
`default_nettype wire

/* File: tb/sfs_supervisor_bench.sv */
`timescale 1ns/1ns
`default_nettype none
module sfs_supervisor_bench;
   // ------
   // signals
   // ------
   logic clk = 1'h0;
   logic rst_n = 1'h0;
   logic off = 1'h1;
   logic hold = 1'h0;
   logic sync = 1'h0;
   logic sync_on = 1'h1;
   logic kill_n = 1'h1;
   logic full = 1'h0;
   logic empty = 1'h0;
   logic sclk, load, h_sda, d_sda, d_oe, sda;
   logic fill, byp, flush, save, rest, echo, shock, rot, sfo, m_oe, m_out;
   logic flush_seen, save_seen, rest_seen, sfo_seen;
   logic [7:0] st;
   // control word, off-track level, hold level, shock expected
   logic [10:0] tbl [6] = '{11'h015, 11'h001, 11'h080, 11'h045, 11'h027, 11'h006};
   int fcnt = 0;
   int n_mismatch = 0;
   int checks_done = 0;
   // shared data line: device wins while it enables its driver
   assign sda = d_oe ? d_sda : h_sda;
   always #5 clk = ~clk;
   sfs_host_model host (.o_sclk(sclk), .o_load(load), .o_sda(h_sda), .i_sda(sda));
   sfs_supervisor #(.FRAME_CYCLES(200)) uut (
      .i_ref_clk(clk), .i_rst_n(rst_n),
      .i_host_serial_clock(sclk), .i_host_load_line(load), .i_host_serial_data(sda),
      .o_host_serial_data(d_sda), .o_host_serial_data_oe(d_oe),
      .i_off_track(off), .i_decoder_hold_marker(hold), .i_frame_sync_marker(sync),
      .i_kill_n(kill_n), .i_mute_req(1'h0), .o_mute_out(m_out), .o_mute_out_oe(m_oe),
      .i_fifo_full(full), .i_fifo_empty(empty), .i_fifo_len(2'h2),
      .o_fill(fill), .o_bypass(byp), .o_flush(flush), .o_save_wptr(save),
      .o_restore_wptr(rest), .o_echo(echo), .o_shock_detected(shock),
      .o_rotational_shock_out(rot), .o_synthetic_frame_out(sfo)
   );
   // frame sync every 200 cycles, gated to fake a lost frame
   always @(negedge clk) begin
      fcnt <= (fcnt == 199) ? 0 : fcnt + 1;
      sync <= sync_on && (fcnt < 4);
   end
   // one-cycle pulses are caught here so the sequence can test them later
   always @(posedge clk) begin
      if (flush) flush_seen <= 1'h1;
      if (save) save_seen <= 1'h1;
      if (rest) rest_seen <= 1'h1;
      if (sfo) sfo_seen <= 1'h1;
   end
   // ------
   // tasks
   // ------
   task automatic cyc(input int n);
      repeat (n) @(negedge clk);
   endtask
   task automatic wr(input logic [7:0] v);
      host.write_ctrl(v);
      cyc(1);
   endtask
   task automatic rd(output logic [7:0] v);
      host.read_stat(v);
      cyc(1);
   endtask
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic stop_test;
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   // watchdog well beyond the expected run of about 2600 cycles
   initial begin
      #200000;
      n_mismatch++;
      stop_test;
   end
   // ------
   // sequence
   // ------
   initial begin
      cyc(16);
      rst_n = 1'h1;
      cyc(8);
      check(byp, 1'h1);
      check(shock, 1'h0);
      kill_n = 1'h0;
      cyc(6);
      check(m_oe, 1'h1);
      check(m_out, 1'h0);
      kill_n = 1'h1;
      rd(st);
      check(st & 8'hC3, 8'h80);
      flush_seen = 1'h0;
      wr(8'h00);
      cyc(4);
      check(byp, 1'h0);
      check(flush_seen, 1'h1);
      check(fill, 1'h1);
      save_seen = 1'h0;
      cyc(220);
      check(save_seen, 1'h1);
      // full ends filling, read clears the flag, found resumes
      full = 1'h1;
      cyc(4);
      check(fill, 1'h0);
      full = 1'h0;
      rd(st);
      check(st[3], 1'h1);
      rd(st);
      check(st[3], 1'h0);
      rest_seen = 1'h0;
      wr(8'h01);
      cyc(4);
      check(rest_seen, 1'h1);
      check(fill, 1'h1);
      // each detector, its persistence and its clearing
      for (int i = 0; i < 6; i++) begin
         wr(tbl[i][10:3]);
         off = tbl[i][2];
         hold = tbl[i][1];
         cyc(8);
         check(shock, tbl[i][0]);
         check(fill, !tbl[i][0]);
         check(rot, tbl[i][1]);
         off = 1'h1;
         hold = 1'h0;
         wr(8'h00);
         cyc(8);
         check(shock, tbl[i][0]);
         wr(8'h01);
         cyc(8);
         check(shock, 1'h0);
      end
      // hold still present after found keeps the shock
      wr(8'h04);
      hold = 1'h1;
      cyc(8);
      wr(8'h05);
      cyc(8);
      check(shock, 1'h1);
      check(fill, 1'h0);
      hold = 1'h0;
      wr(8'h01);
      cyc(8);
      check(shock, 1'h0);
      // echo keeps shock over an empty fifo, flush clears it
      wr(8'h22);
      wr(8'h20);
      empty = 1'h1;
      cyc(6);
      check(echo, 1'h1);
      check(shock, 1'h1);
      empty = 1'h0;
      flush_seen = 1'h0;
      wr(8'h80);
      cyc(4);
      check(flush_seen, 1'h1);
      check(shock, 1'h0);
      wr(8'h02);
      wr(8'h00);
      empty = 1'h1;
      cyc(6);
      check(shock, 1'h0);
      empty = 1'h0;
      // lost frame with full unread, kept last as it re-arms
      sfo_seen = 1'h0;
      sync_on = 1'h0;
      cyc(300);
      check(shock, 1'h1);
      check(sfo_seen, 1'h1);
      sync_on = 1'h1;
      // a real sync must land first, or a late loss re-arms the shock
      cyc(210);
      wr(8'h01);
      cyc(4);
      check(shock, 1'h0);
      stop_test;
   end
endmodule
`default_nettype wire
